// file: rtl/scr_pkg.sv
package scr_pkg;

    // command word layout
    localparam int CMD_W = 29;
    localparam int RW_BIT = 28;
    localparam int CH_HI = 27;
    localparam int CH_LO = 24;
    localparam int TGT_HI = 23;
    localparam int TGT_LO = 22;
    localparam int DATA_W = 22;
    localparam int NUM_CH = 4;

    // data field layout of device_setup_control
    localparam int CL_HI = 21;
    localparam int CL_LO = 18;
    localparam int CPOLH_HI = 17;
    localparam int CPOLH_LO = 14;
    localparam int CPBIAS_BIT = 13;
    localparam int GND_BIT = 12;
    localparam int GALM_BIT = 11;
    localparam int CALM_BIT = 10;
    localparam int INT_BIT = 9;
    localparam int GEN_BIT = 8;
    localparam int GAIN_HI = 7;
    localparam int GAIN_LO = 6;
    localparam int TEN_BIT = 5;
    localparam int TMP_HI = 4;
    localparam int TMP_LO = 3;
    localparam int LATCH_BIT = 2;
    localparam int CTRL_HI = 21;
    localparam int CTRL_LO = 2;
    localparam int UNUSED_W = 2;

    localparam logic [3:0] SYSCTRL_CH = 4'h0;
    localparam logic [1:0] SYSCTRL_TGT = 2'h0;
    localparam logic [UNUSED_W-1:0] UNUSED_RD = 2'h0;

    // field order follows data bits 21 down to 2
    typedef struct packed {
        logic [3:0] clamp_enable;
        logic [3:0] comparator_output_enable;
        logic comparator_power;
        logic ground_sense_per_channel;
        logic guard_alarm_enable;
        logic clamp_alarm_enable;
        logic internal_sense_short;
        logic guard_enable;
        logic [1:0] measure_gain;
        logic thermal_enable;
        logic [1:0] thermal_threshold;
        logic latch_mode;
    } scr_ctrl_t;

    localparam scr_ctrl_t CTRL_RESET = 20'h00000;

    typedef struct packed {
        logic is_read;
        logic [3:0] channel_select;
        logic [1:0] target_select;
        logic [DATA_W-1:0] data;
        logic sel_sysctrl;
    } scr_cmd_t;

endpackage

// file: rtl/scr_cmd_decode.sv
`timescale 1ns/1ps
module scr_cmd_decode (
    input wire logic [scr_pkg::CMD_W-1:0] cmd_word,
    output scr_pkg::scr_cmd_t cmd
);
    always_comb begin
        cmd.is_read = cmd_word[scr_pkg::RW_BIT];
        cmd.channel_select = cmd_word[scr_pkg::CH_HI:scr_pkg::CH_LO];
        cmd.target_select = cmd_word[scr_pkg::TGT_HI:scr_pkg::TGT_LO];
        cmd.data = cmd_word[scr_pkg::DATA_W-1:0];
        cmd.sel_sysctrl = (cmd_word[scr_pkg::CH_HI:scr_pkg::CH_LO] == scr_pkg::SYSCTRL_CH)
            && (cmd_word[scr_pkg::TGT_HI:scr_pkg::TGT_LO] == scr_pkg::SYSCTRL_TGT);
    end
endmodule

// file: rtl/scr_comp_pin.sv
`timescale 1ns/1ps
module scr_comp_pin (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic comp_level,
    input wire logic powered,
    input wire logic out_enable,
    output logic pin_out,
    output logic pin_oe_n
);
    logic next_pin_out;
    logic next_pin_oe_n;

    always_comb begin
        // unpowered comparator reads low so a bused pin never floats a stale level
        next_pin_out = comp_level & powered;
        next_pin_oe_n = ~out_enable;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
        end else begin
            pin_out <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
        end
    end
endmodule

// file: rtl/scr_sys_ctrl.sv
// Summary of operation
// - register selected only when channel and target select bits are all zero
// - one register for the whole device, not one per channel
// - read/write flag zero writes data field into the addressed register
// - read/write flag one starts readback of the addressed register
// - top bits: flag, channel 27..24, target 23..22, clamps 21..18, comparators 17..
// - low bits: comparator 14, power 13, ground 12, alarms 11..10, short 9, ...
// - data bits 1 and 0 are sent as zero and ignored
// - each clamp bit enables its own channel clamp
// - clamp state written by either path; readback returns the latest, a system write winning over a channel write in the same cycle
// - comparator outputs high-impedance at power-on; enable bit drives them
// - comparators powered down at power-on; power bit enables them
// - alarm enable bits let their source pull the shared alarm output
// - guard amplifier off at power-on, enabled by guard enable bit
`timescale 1ns/1ps
module scr_sys_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [scr_pkg::CMD_W-1:0] cmd_word,
    input wire logic [scr_pkg::NUM_CH-1:0] chan_clamp_wr,
    input wire logic [scr_pkg::NUM_CH-1:0] chan_clamp_val,
    input wire logic [scr_pkg::NUM_CH-1:0] chan_comp_oe_wr,
    input wire logic [scr_pkg::NUM_CH-1:0] chan_comp_oe_val,
    input wire logic [scr_pkg::NUM_CH-1:0] comp_level,
    input wire logic [scr_pkg::NUM_CH-1:0] guard_alarm_in,
    input wire logic [scr_pkg::NUM_CH-1:0] clamp_alarm_in,
    output scr_pkg::scr_ctrl_t device_setup_control,
    output logic rd_valid,
    output logic [scr_pkg::DATA_W-1:0] rd_data,
    output logic fwd_valid,
    output logic [scr_pkg::CMD_W-1:0] fwd_word,
    output logic [scr_pkg::NUM_CH-1:0] comp_pin_out,
    output logic [scr_pkg::NUM_CH-1:0] comp_pin_oe_n,
    output logic shared_alarm_output_out,
    output logic shared_alarm_output_oe_n
);
    scr_pkg::scr_cmd_t cmd;
    scr_pkg::scr_ctrl_t next_ctrl;
    logic next_rd_valid;
    logic [scr_pkg::DATA_W-1:0] next_rd_data;
    logic next_fwd_valid;
    logic [scr_pkg::CMD_W-1:0] next_fwd_word;
    logic next_alarm_oe_n;
    logic sys_wr;
    logic sys_rd;

    scr_cmd_decode u_decode (
        .cmd_word(cmd_word),
        .cmd(cmd)
    );

    // register file
    always_comb begin
        sys_wr = cmd_valid && cmd.sel_sysctrl && !cmd.is_read;
        sys_rd = cmd_valid && cmd.sel_sysctrl && cmd.is_read;
        next_ctrl = device_setup_control;
        for (int i = 0; i < scr_pkg::NUM_CH; i++) begin
            if (chan_clamp_wr[i]) begin
                next_ctrl.clamp_enable[i] = chan_clamp_val[i];
            end
            if (chan_comp_oe_wr[i]) begin
                next_ctrl.comparator_output_enable[i] = chan_comp_oe_val[i];
            end
        end
        if (sys_wr) begin
            next_ctrl.clamp_enable = cmd.data[scr_pkg::CL_HI:scr_pkg::CL_LO];
            next_ctrl.comparator_output_enable = cmd.data[scr_pkg::CPOLH_HI:scr_pkg::CPOLH_LO];
            next_ctrl.comparator_power = cmd.data[scr_pkg::CPBIAS_BIT];
            next_ctrl.ground_sense_per_channel = cmd.data[scr_pkg::GND_BIT];
            next_ctrl.guard_alarm_enable = cmd.data[scr_pkg::GALM_BIT];
            next_ctrl.clamp_alarm_enable = cmd.data[scr_pkg::CALM_BIT];
            next_ctrl.internal_sense_short = cmd.data[scr_pkg::INT_BIT];
            next_ctrl.guard_enable = cmd.data[scr_pkg::GEN_BIT];
            next_ctrl.measure_gain = cmd.data[scr_pkg::GAIN_HI:scr_pkg::GAIN_LO];
            next_ctrl.thermal_enable = cmd.data[scr_pkg::TEN_BIT];
            next_ctrl.thermal_threshold = cmd.data[scr_pkg::TMP_HI:scr_pkg::TMP_LO];
            next_ctrl.latch_mode = cmd.data[scr_pkg::LATCH_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            device_setup_control <= scr_pkg::CTRL_RESET;
        end else begin
            device_setup_control <= next_ctrl;
        end
    end

    // readback and forwarding of commands for other registers
    always_comb begin
        next_rd_valid = sys_rd;
        next_rd_data = rd_data;
        if (sys_rd) begin
            next_rd_data = {device_setup_control, scr_pkg::UNUSED_RD};
        end
        // other targets belong to other blocks; pass the whole word on
        next_fwd_valid = cmd_valid && !cmd.sel_sysctrl;
        next_fwd_word = cmd_valid ? cmd_word : fwd_word;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_data <= '0;
            fwd_valid <= 1'b0;
            fwd_word <= '0;
        end else begin
            rd_valid <= next_rd_valid;
            rd_data <= next_rd_data;
            fwd_valid <= next_fwd_valid;
            fwd_word <= next_fwd_word;
        end
    end

    // comparator output pins, one driver per channel
    for (genvar g = 0; g < scr_pkg::NUM_CH; g++) begin : g_comp
        scr_comp_pin u_pin (
            .ref_clk(ref_clk),
            .rst(rst),
            .comp_level(comp_level[g]),
            .powered(device_setup_control.comparator_power),
            .out_enable(device_setup_control.comparator_output_enable[g]),
            .pin_out(comp_pin_out[g]),
            .pin_oe_n(comp_pin_oe_n[g])
        );
    end

    // open-drain alarm: only ever pulls low
    always_comb begin
        next_alarm_oe_n = !((device_setup_control.guard_alarm_enable && (|guard_alarm_in))
            || (device_setup_control.clamp_alarm_enable && (|clamp_alarm_in)));
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shared_alarm_output_out <= 1'b0;
            shared_alarm_output_oe_n <= 1'b1;
        end else begin
            shared_alarm_output_out <= 1'b0;
            shared_alarm_output_oe_n <= next_alarm_oe_n;
        end
    end

    // clamp, guard, gain, thermal and latch fields leave through device_setup_control
endmodule

// file: verif/scr_sys_ctrl_assertions.sv
`timescale 1ns/1ps
module scr_sys_ctrl_assertions (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [28:0] cmd_word,
    input wire logic [3:0] chan_clamp_wr,
    input wire logic [3:0] chan_clamp_val,
    input wire logic [3:0] chan_comp_oe_wr,
    input wire logic [3:0] comp_level,
    input wire logic [3:0] guard_alarm_in,
    input wire logic [3:0] clamp_alarm_in,
    input wire scr_pkg::scr_ctrl_t device_setup_control,
    input wire logic rd_valid,
    input wire logic [21:0] rd_data,
    input wire logic fwd_valid,
    input wire logic [3:0] comp_pin_out,
    input wire logic [3:0] comp_pin_oe_n,
    input wire logic shared_alarm_output_out,
    input wire logic shared_alarm_output_oe_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_wr; cmd_valid && cmd_word[28:22] == 7'h00
        |=> device_setup_control == $past(cmd_word[21:2]); endproperty
    a_wr: assert property (p_wr) else $error("write not stored");
    property p_rd; cmd_valid && cmd_word[28:22] == 7'h40
        |=> rd_valid && !fwd_valid && rd_data == {$past(device_setup_control), 2'h0}; endproperty
    a_rd: assert property (p_rd) else $error("bad readback");
    property p_fwd; cmd_valid && cmd_word[27:22] != 6'h00 |=> fwd_valid && !rd_valid; endproperty
    a_fwd: assert property (p_fwd) else $error("other address acted on");
    property p_hold; !cmd_valid && chan_clamp_wr == 4'h0 && chan_comp_oe_wr == 4'h0
        |=> $stable(device_setup_control); endproperty
    a_hold: assert property (p_hold) else $error("register changed alone");
    property p_clamp; !cmd_valid |=> (device_setup_control.clamp_enable & $past(chan_clamp_wr))
        == $past(chan_clamp_val & chan_clamp_wr); endproperty
    a_clamp: assert property (p_clamp) else $error("channel clamp write lost");
    property p_oe; !$past(rst)
        |-> comp_pin_oe_n == ~$past(device_setup_control.comparator_output_enable); endproperty
    a_oe: assert property (p_oe) else $error("comparator pin enable wrong");
    property p_pwr; !$past(rst) |-> comp_pin_out ==
        ($past(comp_level) & {4{$past(device_setup_control.comparator_power)}}); endproperty
    a_pwr: assert property (p_pwr) else $error("comparator power gating wrong");
    // open drain: only the enable moves
    property p_alm; !$past(rst) |-> !shared_alarm_output_out && shared_alarm_output_oe_n ==
        !$past(|guard_alarm_in && device_setup_control.guard_alarm_enable
        || |clamp_alarm_in && device_setup_control.clamp_alarm_enable); endproperty
    a_alm: assert property (p_alm) else $error("alarm pin wrong");
endmodule
bind scr_sys_ctrl scr_sys_ctrl_assertions u_chk (.ref_clk, .rst, .cmd_valid, .cmd_word,
    .chan_clamp_wr, .chan_clamp_val, .chan_comp_oe_wr, .comp_level, .guard_alarm_in,
    .clamp_alarm_in, .device_setup_control, .rd_valid, .rd_data, .fwd_valid, .comp_pin_out,
    .comp_pin_oe_n, .shared_alarm_output_out, .shared_alarm_output_oe_n);

// file: verif/scr_host_model.sv
`timescale 1ns/1ps
module scr_host_model (
    input wire logic ref_clk,
    output logic cmd_valid,
    output logic [28:0] cmd_word
);
    initial begin
        cmd_valid = 1'b0;
        cmd_word = 29'h0;
    end
    task send(input logic [28:0] w, input int gap);
        cmd_valid <= 1'b1;
        cmd_word <= w;
        @(negedge ref_clk);
        if (gap > 0) begin
            // released bus shows no stale word
            cmd_valid <= 1'b0;
            cmd_word <= ~w;
            repeat (gap) @(negedge ref_clk);
        end
    endtask
endmodule

// file: verif/scr_sys_ctrl_test.sv
`timescale 1ns/1ps
module scr_sys_ctrl_test;
    logic ref_clk = 1'b0, rst = 1'b1, cmd_valid;
    logic [28:0] cmd_word, fwd_word, w;
    logic [3:0] cw = 4'h0, cv = 4'h0, ow = 4'h0, ov = 4'h0, lvl = 4'h0, ga = 4'h0, ca = 4'h0;
    logic [3:0] pin, oe_n;
    logic rd_valid, fwd_valid, a_out, a_oe_n;
    logic [21:0] rd_data;
    logic [19:0] m = 20'h0;
    logic [31:0] s = 32'h140b;
    scr_pkg::scr_ctrl_t dsc;
    logic [28:0] q[$];
    int bad_count = 0, tests_run = 0, cyc = 0;
    scr_host_model host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word));
    scr_sys_ctrl dut (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_word(cmd_word), .chan_clamp_wr(cw), .chan_clamp_val(cv), .chan_comp_oe_wr(ow),
        .chan_comp_oe_val(ov), .comp_level(lvl), .guard_alarm_in(ga), .clamp_alarm_in(ca),
        .device_setup_control(dsc), .rd_valid(rd_valid), .rd_data(rd_data),
        .fwd_valid(fwd_valid), .fwd_word(fwd_word), .comp_pin_out(pin), .comp_pin_oe_n(oe_n),
        .shared_alarm_output_out(a_out), .shared_alarm_output_oe_n(a_oe_n));
    initial forever #5 ref_clk = ~ref_clk;
    function logic [31:0] xs();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task chk(input logic [28:0] g, input logic [28:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task end_sim;
        $display("compares %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // readback of sysctrl, data all zero; idle cycle after so no command repeats
    task rd;
        q.push_back({7'h0, m, 2'h0});
        host.send(29'h10000000, 1);
    endtask
    task chan(input logic [3:0] a, b, c, d);
        {cw, cv, ow, ov} <= {a, b, c, d};
        m[19:16] = (m[19:16] & ~a) | (b & a);
        m[15:12] = (m[15:12] & ~c) | (d & c);
        @(negedge ref_clk);
        {cw, ow} <= 8'h00;
    endtask
    always @(negedge ref_clk) begin
        {lvl, ga, ca} <= xs();
        if (!rst && (rd_valid === 1'b1 || fwd_valid === 1'b1))
            chk(rd_valid ? {7'h0, rd_data} : fwd_word, q.size() ? q.pop_front() : 'x);
    end
    always @(posedge ref_clk) if (++cyc == 3000) begin
        bad_count++;
        end_sim;
    end
    initial begin
        repeat (3) @(negedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk({a_out, a_oe_n, oe_n}, 6'h1f);
        rd;
        $display("reset test done");
        // each write followed at once by a readback, unused bits sent as zero
        for (int i = 0; i < 16; i++) begin
            w = xs();
            m = w[21:2];
            host.send({7'h0, w[21:2], 2'h0}, 0);
            rd;
        end
        $display("write test done");
        // every third nonzero channel/target value, 1 to 61, goes elsewhere
        for (int k = 1; k < 64; k += 3) begin
            w = {xs(), 6'(k), xs()} >> 32;
            w[27:22] = 6'(k);
            q.push_back(w);
            host.send(w, (k > 60) ? 1 : 0);
        end
        $display("forward test done");
        chan(4'h5, 4'h5, 4'ha, 4'ha);
        rd;
        m = 20'hfff00;
        host.send(29'h003ffc00, 1);
        chan(4'h3, 4'h0, 4'h0, 4'h0);
        rd;
        host.send(29'h0, 20);
        chk(29'(q.size()), 29'h0);
        $display("channel test done");
        end_sim;
    end
endmodule
